/* hdl/amm_pkg.sv */
// Register map, fault bit positions and reset values of the alarm monitor.
package amm_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_MASK = 8'h00;
  localparam logic [7:0] ADDR_TX_ALARM_SEL = 8'h04;
  localparam logic [7:0] ADDR_RX_ALARM_EN = 8'h08;
  localparam logic [7:0] ADDR_EBNO_THR = 8'h0c;
  localparam logic [7:0] ADDR_LEVEL_THR = 8'h10;
  localparam logic [7:0] ADDR_MODE = 8'h14;
  localparam logic [7:0] ADDR_FAULT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;

  // Fault vector bit positions, shared by mask, fault, status and irq mask.
  localparam int F_TX_ALL_ONES = 0;
  localparam int F_RX_ALL_ONES = 1;
  localparam int F_BUF_SLIP = 2;
  localparam int F_AGC = 3;
  localparam int F_EBNO = 4;
  localparam int F_RX_ALARM = 5;
  localparam int F_RX_TERR = 6;
  localparam int NUM_FAULTS = 7;

  // Mode register bit: drop-and-insert operation configured.
  localparam int MODE_DI = 0;

  // Transmit backward alarm source codes, two bits per alarm.
  localparam logic [1:0] ALARM_SRC_OFF = 2'h0;
  localparam logic [1:0] ALARM_SRC_HW = 2'h1;
  localparam logic [1:0] ALARM_SRC_SW = 2'h2;
  localparam int NUM_TX_ALARMS = 4;

  // Receive level threshold, -20 dBm, held in signed tenths of a dBm.
  localparam logic signed [15:0] LEVEL_THR_RST = 16'hff38;
  localparam logic [7:0] EBNO_THR_RST = 8'h00;

  // Mask reset value: every fault setting masked (1 = active).
  localparam logic [NUM_FAULTS-1:0] MASK_RST = 7'h00;

endpackage

/* hdl/amm_alarm_mask_monitor.sv */
// Alarm detection, masking and backward alarm routing with Wishbone registers.
// Functional notes
// - Active transmit all-ones setting faults on terrestrial all-ones data.
// - Active receive all-ones setting faults on received all-ones data.
// - Masked conditions raise no alarm; active ones report their condition.
// - Active buffer slip setting faults on buffer underflow or overflow.
// - Active level alarm faults when receive level exceeds the level threshold, minus 20 dBm at reset.
// - Active Eb/No alarm faults when Eb/No drops below threshold.
// - Each transmit backward alarm selects hardware, software or off.
// - Hardware follows its input; software follows the receive fault status.
// - Only received backward alarms set to yes are monitored.
// - Terrestrial alarm settings count only in drop-and-insert operation.
`timescale 1ns/1ps

module amm_alarm_mask_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Asynchronous condition inputs from the modem datapath
  input wire logic tx_terr_all_ones_i,
  input wire logic rx_sat_all_ones_i,
  input wire logic rx_terr_alarm_i,
  input wire logic buf_underflow_i,
  input wire logic buf_overflow_i,
  input wire logic [3:0] backward_alarm_rx_i,
  input wire logic [3:0] backward_alarm_hw_i,
  // Measurements from the demodulator, same clock domain
  input wire logic signed [15:0] rx_level_i,
  input wire logic [7:0] rx_ebno_i,
  // Alarm outputs
  output logic [6:0] fault_o,
  output logic rx_fault_o,
  output logic [3:0] backward_alarm_tx_o,
  output logic irq_o
);

  localparam int NF = amm_pkg::NUM_FAULTS;
  localparam int NA = amm_pkg::NUM_TX_ALARMS;

  // Settings written by software.
  logic [NF-1:0] alarm_mask;
  logic [2*NA-1:0] tx_alarm_sel;
  logic [NA-1:0] rx_alarm_en;
  logic [7:0] ebno_thr;
  logic signed [15:0] level_thr;
  logic di_mode;
  logic [NF-1:0] irq_mask;

  // Pin synchroniser stages and the levels taken from the second stage.
  logic [12:0] sync1;
  logic [12:0] sync2;
  logic tx_ones_s;
  logic rx_ones_s;
  logic rx_terr_s;
  logic underflow_s;
  logic overflow_s;
  logic [NA-1:0] rx_alarm_s;
  logic [NA-1:0] hw_alarm_s;

  // Condition, fault and interrupt state.
  logic slip_level;
  logic slip_prev;
  logic [NF-1:0] cond;
  logic [NF-1:0] fault;
  logic [NF-1:0] fault_prev;
  logic [NF-1:0] fault_rise;
  logic [NF-1:0] irq_status;
  logic [NF-1:0] next_status;

  // Bus decode.
  logic bus_req;
  logic wr_req;
  logic rd_req;
  logic status_read;
  logic [31:0] rd_word;

  // Selects one transmit backward alarm source.
  function automatic logic tx_alarm_route(input logic [1:0] sel,
                                          input logic hw,
                                          input logic sw);
    case (sel)
      amm_pkg::ALARM_SRC_HW: tx_alarm_route = hw;
      amm_pkg::ALARM_SRC_SW: tx_alarm_route = sw;
      default: tx_alarm_route = 1'b0;
    endcase
  endfunction

  // True when a write request hits the given register and byte lane.
  function automatic logic lane_write(input logic req,
                                      input logic [7:0] adr,
                                      input logic [7:0] target,
                                      input logic lane);
    lane_write = req & lane & (adr == target);
  endfunction

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 13'h0000;
      sync2 <= 13'h0000;
    end else begin
      sync1 <= {backward_alarm_hw_i, backward_alarm_rx_i, buf_overflow_i,
                buf_underflow_i, rx_terr_alarm_i, rx_sat_all_ones_i,
                tx_terr_all_ones_i};
      sync2 <= sync1;
    end
  end

  assign tx_ones_s = sync2[0];
  assign rx_ones_s = sync2[1];
  assign rx_terr_s = sync2[2];
  assign underflow_s = sync2[3];
  assign overflow_s = sync2[4];
  assign rx_alarm_s = sync2[8:5];
  assign hw_alarm_s = sync2[12:9];

  // A slip event is the rising edge of the OR of the two buffer flags.
  assign slip_level = underflow_s | overflow_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slip_prev <= 1'b0;
    end else begin
      slip_prev <= slip_level;
    end
  end

  // Raw conditions are always evaluated, independent of the mask.
  always_comb begin
    cond = '0;
    cond[amm_pkg::F_TX_ALL_ONES] = tx_ones_s;
    cond[amm_pkg::F_RX_ALL_ONES] = rx_ones_s;
    cond[amm_pkg::F_RX_TERR] = rx_terr_s;
    cond[amm_pkg::F_BUF_SLIP] = slip_level & ~slip_prev;
    cond[amm_pkg::F_AGC] = rx_level_i > level_thr;
    cond[amm_pkg::F_EBNO] = rx_ebno_i < ebno_thr;
    cond[amm_pkg::F_RX_ALARM] = |(rx_alarm_s & rx_alarm_en);
  end

  // Faults are the conditions gated by their active settings.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault <= '0;
    end else begin
      fault <= cond & alarm_mask;
      if (!di_mode) begin
        fault[amm_pkg::F_TX_ALL_ONES] <= 1'b0;
        fault[amm_pkg::F_RX_TERR] <= 1'b0;
      end
    end
  end

  assign fault_o = fault;

  // Receive fault summary feeds software-routed backward alarms.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_fault_o <= 1'b0;
    end else begin
      rx_fault_o <= |(fault & ~(NF'(1) << amm_pkg::F_TX_ALL_ONES));
    end
  end

  // Transmit backward alarms: hardware pin, software fault or off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backward_alarm_tx_o <= 4'h0;
    end else begin
      for (int i = 0; i < NA; i++) begin
        backward_alarm_tx_o[i] <= tx_alarm_route(tx_alarm_sel[2*i +: 2],
                                                 hw_alarm_s[i],
                                                 rx_fault_o);
      end
    end
  end

  // Wishbone access: single-cycle acknowledge, dropped the cycle after.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_req = bus_req & wb_we_i;
  assign rd_req = bus_req & ~wb_we_i;
  assign status_read = rd_req & (wb_adr_i == amm_pkg::ADDR_IRQ_STATUS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Alarm mask: one bit per fault, 1 = active.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_mask <= amm_pkg::MASK_RST;
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_MASK,
                            wb_sel_i[0])) begin
      alarm_mask <= wb_dat_i[NF-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_alarm_sel <= {NA{amm_pkg::ALARM_SRC_OFF}};
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_TX_ALARM_SEL,
                            wb_sel_i[0])) begin
      tx_alarm_sel <= wb_dat_i[2*NA-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_alarm_en <= '0;
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_RX_ALARM_EN,
                            wb_sel_i[0])) begin
      rx_alarm_en <= wb_dat_i[NA-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ebno_thr <= amm_pkg::EBNO_THR_RST;
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_EBNO_THR,
                            wb_sel_i[0])) begin
      ebno_thr <= wb_dat_i[7:0];
    end
  end

  // The level threshold is signed and spans two byte lanes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_thr <= amm_pkg::LEVEL_THR_RST;
    end else begin
      if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_LEVEL_THR,
                     wb_sel_i[0])) begin
        level_thr[7:0] <= wb_dat_i[7:0];
      end
      if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_LEVEL_THR,
                     wb_sel_i[1])) begin
        level_thr[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      di_mode <= 1'b0;
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_MODE,
                            wb_sel_i[0])) begin
      di_mode <= wb_dat_i[amm_pkg::MODE_DI];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= '0;
    end else if (lane_write(wr_req, wb_adr_i, amm_pkg::ADDR_IRQ_MASK,
                            wb_sel_i[0])) begin
      irq_mask <= wb_dat_i[NF-1:0];
    end
  end

  // Rising faults set sticky bits; a new event wins over the read clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_prev <= '0;
    end else begin
      fault_prev <= fault;
    end
  end

  assign fault_rise = fault & ~fault_prev;

  always_comb begin
    next_status = status_read ? '0 : irq_status;
    next_status = next_status | fault_rise;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_status;
    end
  end

  // The level interrupt follows the status it is computed from.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & irq_mask);
    end
  end

  // Unmapped addresses read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (wb_adr_i)
      amm_pkg::ADDR_MASK: rd_word = {25'h0, alarm_mask};
      amm_pkg::ADDR_TX_ALARM_SEL: rd_word = {24'h0, tx_alarm_sel};
      amm_pkg::ADDR_RX_ALARM_EN: rd_word = {28'h0, rx_alarm_en};
      amm_pkg::ADDR_EBNO_THR: rd_word = {24'h0, ebno_thr};
      amm_pkg::ADDR_LEVEL_THR: rd_word = {16'h0, level_thr};
      amm_pkg::ADDR_MODE: rd_word = {31'h0, di_mode};
      amm_pkg::ADDR_FAULT: rd_word = {25'h0, fault};
      amm_pkg::ADDR_IRQ_STATUS: rd_word = {25'h0, irq_status};
      amm_pkg::ADDR_IRQ_MASK: rd_word = {25'h0, irq_mask};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is registered and stands until the next read.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
      wb_dat_o <= rd_word;
    end
  end

endmodule

/* dv/amm_far_end.sv */
// Behavioural model of the modem datapath driving the condition pins.
`timescale 1ns/1ps
module amm_far_end (
  // Clock
  input wire logic clk_i,
  // Pin levels wanted by the bench
  input wire logic [12:0] want_i,
  // Condition pins toward the block
  output logic [12:0] pins_o
);
  // Levels move just after an edge, like a real registered source.
  initial pins_o = 13'h0;
  always @(posedge clk_i) begin
    pins_o <= want_i;
  end
endmodule

/* dv/amm_checker_assertions.sv */
// Port assertions for the alarm mask monitor.
`timescale 1ns/1ps
module amm_checker (
  // Clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Conditions and alarms
  input wire logic tx_terr_all_ones_i,
  input wire logic rx_sat_all_ones_i,
  input wire logic buf_underflow_i,
  input wire logic buf_overflow_i,
  input wire logic [3:0] backward_alarm_rx_i,
  input wire logic [3:0] backward_alarm_hw_i,
  input wire logic [6:0] fault_o,
  input wire logic rx_fault_o,
  input wire logic [3:0] backward_alarm_tx_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_tx_ones; fault_o[0] |-> $past(tx_terr_all_ones_i, 3); endproperty
  property p_rx_ones; fault_o[1] |-> $past(rx_sat_all_ones_i, 3); endproperty
  property p_slip;
    fault_o[2] |-> $past(buf_underflow_i || buf_overflow_i, 3);
  endproperty
  property p_slip_pulse; fault_o[2] |=> !fault_o[2]; endproperty
  property p_rx_alarm;
    fault_o[5] |-> |$past(backward_alarm_rx_i, 3);
  endproperty
  property p_rx_fault;
    rx_fault_o |-> (|fault_o[6:1]) || $past(|fault_o[6:1]);
  endproperty
  property p_tx_alarm;
    |backward_alarm_tx_o |-> $past(|backward_alarm_hw_i, 3) ||
      $past(|backward_alarm_hw_i, 4) || $past(rx_fault_o) || $past(rx_fault_o, 2);
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_tx_ones: assert property (p_tx_ones) else $error("fault 0 bad");
  a_rx_ones: assert property (p_rx_ones) else $error("fault 1 bad");
  a_slip: assert property (p_slip) else $error("slip bad");
  a_slip_pulse: assert property (p_slip_pulse) else $error("slip long");
  a_rx_alarm: assert property (p_rx_alarm) else $error("fault 5 bad");
  a_rx_fault: assert property (p_rx_fault) else $error("rx fault bad");
  a_tx_alarm: assert property (p_tx_alarm) else $error("tx alarm bad");
endmodule
bind amm_alarm_mask_monitor amm_checker chk_u (.*);

/* dv/testbench.sv */
// Self-checking bench for the alarm mask monitor.
`timescale 1ns/1ps
module testbench;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, rxf;
  logic [7:0] adr, ebno;
  logic [31:0] wdat, rdat, r;
  logic [15:0] lvl;
  logic [12:0] want, p;
  logic [6:0] flt;
  logic [3:0] btx;
  int failures, checks_done;
  amm_far_end far_u (.clk_i(clk_i), .want_i(want), .pins_o(p));
  amm_alarm_mask_monitor dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .tx_terr_all_ones_i(p[0]), .rx_sat_all_ones_i(p[1]),
    .rx_terr_alarm_i(p[2]), .buf_underflow_i(p[3]), .buf_overflow_i(p[4]),
    .backward_alarm_rx_i(p[8:5]), .backward_alarm_hw_i(p[12:9]),
    .rx_level_i(lvl), .rx_ebno_i(ebno), .fault_o(flt), .rx_fault_o(rxf),
    .backward_alarm_tx_o(btx), .irq_o(irq));
  task xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    n = 0;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: no bus acknowledge", $time);
    end
    r = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task cf(input logic [6:0] e);
    chk({25'h0, flt}, {25'h0, e});
  endtask
  task final_report;
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    failures++;
    final_report;
  end
  initial begin
    {rst_i, cyc, stb, we, adr, wdat, want} = {4'h8, 8'h0, 32'h0, 13'h0};
    {lvl, ebno, failures, checks_done} = {16'h8000, 8'h0, 64'h0};
    wt(2);
    rst_i <= 1'b0;
    rd(amm_pkg::ADDR_MASK, 32'h0);
    rd(8'h30, 32'h0);
    xf(1'b1, amm_pkg::ADDR_MASK, 32'h7f);
    xf(1'b1, amm_pkg::ADDR_MODE, 32'h1);
    xf(1'b1, amm_pkg::ADDR_IRQ_MASK, 32'h7f);
    want <= 13'h1;
    wt(6);
    cf(7'h1);
    want <= 13'h2;
    wt(6);
    cf(7'h2);
    chk({31'h0, irq}, 32'h1);
    rd(amm_pkg::ADDR_IRQ_STATUS, 32'h3);
    wt(2);
    chk({31'h0, irq}, 32'h0);
    xf(1'b1, amm_pkg::ADDR_MASK, 32'h7d);
    wt(2);
    cf(7'h0);
    xf(1'b1, amm_pkg::ADDR_MASK, 32'h7f);
    wt(2);
    cf(7'h2);
    xf(1'b1, amm_pkg::ADDR_MODE, 32'h0);
    want <= 13'h5;
    wt(6);
    cf(7'h0);
    xf(1'b1, amm_pkg::ADDR_MODE, 32'h1);
    wt(2);
    cf(7'h41);
    xf(1'b1, amm_pkg::ADDR_TX_ALARM_SEL, 32'hc9);
    want <= 13'h1e04;
    wt(8);
    chk({31'h0, rxf}, 32'h1);
    chk({28'h0, btx}, 32'h3);
    want <= 13'h1e00;
    wt(8);
    chk({31'h0, rxf}, 32'h0);
    chk({28'h0, btx}, 32'h1);
    xf(1'b1, amm_pkg::ADDR_RX_ALARM_EN, 32'h2);
    want <= 13'h20;
    wt(6);
    cf(7'h0);
    want <= 13'h40;
    wt(6);
    cf(7'h20);
    want <= 13'h0;
    wt(6);
    xf(1'b0, amm_pkg::ADDR_IRQ_STATUS, 32'h0);
    want <= 13'h8;
    wt(6);
    rd(amm_pkg::ADDR_IRQ_STATUS, 32'h4);
    xf(1'b1, amm_pkg::ADDR_IRQ_MASK, 32'h7b);
    want <= 13'h0;
    wt(4);
    want <= 13'h10;
    wt(6);
    chk({31'h0, irq}, 32'h0);
    rd(amm_pkg::ADDR_IRQ_STATUS, 32'h4);
    lvl <= 16'hff39;
    wt(3);
    cf(7'h8);
    lvl <= 16'hff38;
    wt(3);
    cf(7'h0);
    xf(1'b1, amm_pkg::ADDR_EBNO_THR, 32'ha);
    ebno <= 8'h9;
    wt(3);
    cf(7'h10);
    ebno <= 8'ha;
    wt(3);
    cf(7'h0);
    final_report;
  end
endmodule
